/* bench/alsm_field_model.sv */
module alsm_field_model import alsm_pkg::*; #(
  parameter int NU = 4
) (
  // Clock
  input wire logic core_clk,
  // Raw sources toward the block
  output logic [NU*ALM_BITS-1:0] alarmSrc,
  output logic [NU-1:0] relaySrc,
  output logic [NU-1:0] openLim,
  output logic [NU-1:0] closedLim,
  output logic [SYS_ALMS-1:0] sysSrc,
  output logic [5:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // All field inputs quiet at power up
  initial begin
    alarmSrc = '0;
    relaySrc = '0;
    openLim = '0;
    closedLim = '0;
    sysSrc = '0;
    flags = '0;
  end
  // One change per edge, so two puts make a one-cycle transient
  task automatic put(input int kind, input int idx, input logic [15:0] v);
    @(posedge core_clk);
    case (kind)
      0: alarmSrc[idx] <= v[0];
      1: relaySrc[idx] <= v[0];
      2: sysSrc <= v[SYS_ALMS-1:0];
      3: openLim <= v[NU-1:0];
      4: closedLim <= v[NU-1:0];
      default: flags <= v[5:0];
    endcase
  endtask : put
endmodule : alsm_field_model

/* bench/tb_alarm_latch_status_map.sv */
module tb_alarm_latch_status_map import alsm_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NU = 4;
  localparam int LIMIT = 6000;
  // Bus, trigger and alarm nets
  logic core_clk, arst_n, hsel, hwrite, hreadyOut, hresp, esdT, chgT, rstT;
  logic rdPend = 1'b0; // Read data phase due at the next edge
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, cuAlm, caAlm;
  logic [NU*ALM_BITS-1:0] alarmSrc;
  logic [NU-1:0] relaySrc, openLim, closedLim;
  logic [SYS_ALMS-1:0] sysSrc, s;
  logic [5:0] flags;
  logic [7:0] lfsr;
  // Expected results, oldest first
  logic [31:0] rdQ[$];
  logic [2:0] trigQ[$];
  int mismatches = 0;
  int totalChecks = 0;
  int cycles = 0;
  int flagLoc[6] = '{LOC_LOOP_BUSY, LOC_LOOP_USED, LOC_MAIN_OK, LOC_STANDBY_OK, LOC_CONTACT,
    LOC_PRIMARY};
  // Coil commands: code, quantity, start, expected trigger vector
  logic [34:0] cmds[8] = '{{8'h05, 8'h00, 16'h0000, 3'h1}, {8'h05, 8'h00, 16'h000E, 3'h2},
    {8'h05, 8'h00, 16'h000F, 3'h4}, {8'h0F, 8'h02, 16'h000E, 3'h6},
    {8'h0F, 8'h01, 16'h0000, 3'h1}, {8'h06, 8'h00, 16'h0000, 3'h0},
    {8'h0F, 8'h00, 16'h0000, 3'h0}, {8'h0F, 8'h20, 16'h0000, 3'h7}};

  alsm_field_model #(.NU(NU)) fm (.core_clk(core_clk), .alarmSrc(alarmSrc),
    .relaySrc(relaySrc), .openLim(openLim), .closedLim(closedLim), .sysSrc(sysSrc),
    .flags(flags));
  alsm_top #(.NUM_UNITS(NU)) dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyOut),
    .hwdata(hwdata), .hreadyout(hreadyOut), .hresp(hresp), .hrdata(hrdata),
    .fieldUnitAlarmSrc(alarmSrc), .monitorRelaySrc(relaySrc), .openLimitStatus(openLim),
    .closedLimitStatus(closedLim), .sysAlarmSrc(sysSrc), .loopbackBusy(flags[0]),
    .loopbackInUse(flags[1]), .mainUnitOk(flags[2]), .standbyUnitOk(flags[3]),
    .contactRight(flags[4]), .primaryUnit(flags[5]), .emergencyShutdownTrigger(esdT),
    .changeMasterTrigger(chgT), .loopResetTrigger(rstT), .commonUnitAlarm(cuAlm),
    .commonActuatorAlarm(caAlm));

  // Free-running 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Pseudo-random source pattern
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  // Record image: alarm block, summary, new alarm
  function automatic logic [31:0] rec(input logic [15:0] a, input logic nw, input logic sm);
    return {3'h0, a, sm, nw, 11'h000};
  endfunction : rec
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("mismatches=%0d checks=%0d", mismatches, totalChecks);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // Single AHB-Lite word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyOut !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyOut !== 1'b1);
  endtask : xfer
  // Read with its expected word noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // Discrete read by one-based location, sent zero-based
  task automatic disc(input int loc, input logic e);
    xfer(1'b1, OFF_DISC_ADDR, 32'(loc - DISC_LOC_BASE));
    rd(OFF_DISC_DATA, {31'h0, e});
  endtask : disc
  // Coil write; the coil value itself is not carried
  task automatic coil(input logic [34:0] c);
    if (c[2:0] !== 3'h0) trigQ.push_back(c[2:0]);
    xfer(1'b1, OFF_COIL_CMD, c[34:3]);
  endtask : coil
  // Alarm accept is coil 32, zero-based 31
  task automatic accept();
    coil({FC_WRITE_COIL, 8'h00, 16'h001F, 3'h0});
    // Latch drops two edges after the accept pulse; let it settle before the next read
    @(posedge core_clk);
  endtask : accept
  // Watcher: read data one edge after the address phase, trigger pulses, hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (rdPend && rdQ.size() > 0) chk(hrdata, rdQ.pop_front());
    if (rdPend) chk({31'h0, hresp}, 32'h0);
    rdPend = hsel && htrans[1] && !hwrite && hreadyOut;
    if (arst_n && {rstT, chgT, esdT} !== 3'h0) begin
      if (trigQ.size() > 0) chk({29'h0, rstT, chgT, esdT}, {29'h0, trigQ.pop_front()});
      else chk({29'h0, rstT, chgT, esdT}, 32'h0);
    end
    if (cycles == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    arst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    lfsr = 8'h60;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    // Defaults, refused store, unmapped place
    rd(OFF_STORE_SEL, 32'h0);
    rd(OFF_UNIT_SEL, 32'h1);
    rd(OFF_DISC_ADDR, 32'h0);
    xfer(1'b1, OFF_STORE_SEL, 32'h3);
    rd(OFF_STORE_SEL, 32'h0);
    xfer(1'b1, 8'h1C, 32'hFFFF);
    rd(8'h1C, 32'h0);
    // Transient thermostat trip on unit 1
    fm.put(0, THERMO_SRC_IDX, 16'h1);
    fm.put(0, THERMO_SRC_IDX, 16'h0);
    repeat (2) @(posedge core_clk);
    #1;
    chk({29'h0, cuAlm}, 32'h7);
    xfer(1'b1, OFF_STORE_SEL, 32'h1);
    accept();
    rd(OFF_UNIT_REC, rec(16'h0040, 1'b0, 1'b1));
    xfer(1'b1, OFF_STORE_SEL, 32'h0);
    rd(OFF_UNIT_REC, rec(16'h0040, 1'b1, 1'b1));
    accept();
    rd(OFF_UNIT_REC, 32'h0);
    chk({29'h0, cuAlm}, 32'h6);
    xfer(1'b1, OFF_STORE_SEL, 32'h1);
    rd(OFF_UNIT_REC, rec(16'h0040, 1'b0, 1'b1));
    accept();
    rd(OFF_UNIT_REC, 32'h0);
    // Persisting alarm: accepted while high, clears when it drops
    xfer(1'b1, OFF_STORE_SEL, 32'h0);
    fm.put(0, 0, 16'h1);
    rd(OFF_UNIT_REC, rec(16'h0001, 1'b1, 1'b1));
    accept();
    rd(OFF_UNIT_REC, rec(16'h0001, 1'b0, 1'b1));
    fm.put(0, 0, 16'h0);
    rd(OFF_UNIT_REC, 32'h0);
    // Monitor relay transient
    fm.put(1, 0, 16'h1);
    fm.put(1, 0, 16'h0);
    repeat (2) @(posedge core_clk);
    #1;
    chk({29'h0, caAlm}, 32'h7);
    disc(LOC_COMMON_ACT, 1'b1);
    accept();
    rd(OFF_STATUS, 32'h66);
    disc(LOC_COMMON_UNIT, 1'b0);
    // System alarms, then reserved places
    lfsr = nxt(lfsr);
    s = lfsr[4:0] | 5'h01;
    fm.put(2, 0, {11'h0, s});
    fm.put(2, 0, 16'h0);
    for (int i = 0; i < SYS_ALMS; i++) disc(LOC_SYS_FIRST + i, s[i]);
    accept();
    for (int i = 0; i < SYS_ALMS; i++) disc(LOC_SYS_FIRST + i, 1'b0);
    disc(DISC_LOC_BASE, 1'b0);
    disc(10246, 1'b0);
    // Status flags
    lfsr = nxt(lfsr);
    fm.put(5, 0, {10'h0, lfsr[5:0]});
    for (int i = 0; i < 6; i++) disc(flagLoc[i], lfsr[i]);
    // Limit bits, paired and mirrored
    lfsr = nxt(lfsr);
    fm.put(3, 0, {12'h0, lfsr[3:0]});
    fm.put(4, 0, {12'h0, lfsr[7:4]});
    rd(OFF_UNIT_REC, {28'h0, lfsr[4], lfsr[0], 2'h0});
    // Second unit through the unit select register
    xfer(1'b1, OFF_UNIT_SEL, 32'h2);
    rd(OFF_UNIT_SEL, 32'h2);
    rd(OFF_UNIT_REC, {28'h0, lfsr[5], lfsr[1], 2'h0});
    for (int n = 1; n <= NU; n++) begin
      disc(LOC_LIMIT_BASE + 2 * n - 1, lfsr[n + 3]);
      disc(LOC_LIMIT_BASE + 2 * n, lfsr[n - 1]);
      disc(LOC_OPEN_MIRROR + n - 1, lfsr[n - 1]);
      disc(LOC_CLOSED_MIRROR + n - 1, lfsr[n + 3]);
    end
    // Trigger coils by both write codes, plus ignored commands
    foreach (cmds[i]) coil(cmds[i]);
    repeat (4) @(posedge core_clk);
    chk(32'(rdQ.size() + trigQ.size()), 32'h0);
    tally_and_finish();
  end
endmodule : tb_alarm_latch_status_map

/* design/alsm_pkg.sv */
package alsm_pkg;
  // Store and field sizes
  localparam int NUM_STORES = 3;
  localparam int ALM_BITS = 16;
  localparam int SYS_ALMS = 5;
  localparam int NUM_TRIG = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_STORE_SEL = 8'h00;
  localparam logic [7:0] OFF_UNIT_SEL = 8'h04;
  localparam logic [7:0] OFF_UNIT_REC = 8'h08;
  localparam logic [7:0] OFF_DISC_ADDR = 8'h0C;
  localparam logic [7:0] OFF_DISC_DATA = 8'h10;
  localparam logic [7:0] OFF_COIL_CMD = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // Reset values
  localparam logic [1:0] STORE_SEL_RST = 2'h0;
  localparam logic [7:0] UNIT_SEL_RST = 8'h01;
  localparam logic [15:0] DISC_ADDR_RST = 16'h0000;
  // Unit record fields
  localparam int REC_OPEN_BIT = 2;
  localparam int REC_CLOSED_BIT = 3;
  localparam int REC_NEW_BIT = 11;
  localparam int REC_SUM_BIT = 12;
  localparam int REC_ALM_LSB = 13;
  localparam int REC_THERMO_BIT = 19;
  localparam int THERMO_SRC_IDX = REC_THERMO_BIT - REC_ALM_LSB;
  // Status register fields
  localparam int STAT_UNIT_LSB = 0;
  localparam int STAT_ACT_LSB = 4;
  // Coil command fields
  localparam int CMD_FC_LSB = 24;
  localparam int CMD_QTY_LSB = 16;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  // One-based discrete locations
  localparam int DISC_LOC_BASE = 10001;
  localparam int LOC_SYS_FIRST = 10241;
  localparam int LOC_LOOP_BUSY = 10248;
  localparam int LOC_LOOP_USED = 10249;
  localparam int LOC_COMMON_UNIT = 10250;
  localparam int LOC_COMMON_ACT = 10251;
  localparam int LOC_MAIN_OK = 10252;
  localparam int LOC_STANDBY_OK = 10253;
  localparam int LOC_CONTACT = 10254;
  localparam int LOC_PRIMARY = 10255;
  localparam int LOC_LIMIT_BASE = 10256;
  localparam int LOC_OPEN_MIRROR = 11217;
  localparam int LOC_CLOSED_MIRROR = 11457;
  // One-based coil locations
  localparam int COIL_LOC_BASE = 1;
  localparam int TRIG_ESD = 0;
  localparam int TRIG_CHANGE = 1;
  localparam int TRIG_RESET = 2;
  localparam int TRIG_ACCEPT = 3;
  localparam int COIL_LOC [NUM_TRIG] = '{1, 15, 16, 32};
endpackage : alsm_pkg

/* design/alsm_top.sv */
// The AHB-Lite register port and the placing of the registers were decided locally.
module alsm_top import alsm_pkg::*; #(
  parameter int NUM_UNITS = 240
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Field unit sources
  input wire logic [NUM_UNITS*ALM_BITS-1:0] fieldUnitAlarmSrc,
  input wire logic [NUM_UNITS-1:0] monitorRelaySrc,
  input wire logic [NUM_UNITS-1:0] openLimitStatus,
  input wire logic [NUM_UNITS-1:0] closedLimitStatus,
  // System sources and flags
  input wire logic [SYS_ALMS-1:0] sysAlarmSrc,
  input wire logic loopbackBusy,
  input wire logic loopbackInUse,
  input wire logic mainUnitOk,
  input wire logic standbyUnitOk,
  input wire logic contactRight,
  input wire logic primaryUnit,
  // Trigger pulses
  output logic emergencyShutdownTrigger,
  output logic changeMasterTrigger,
  output logic loopResetTrigger,
  // Common alarms per store
  output logic [NUM_STORES-1:0] commonUnitAlarm,
  output logic [NUM_STORES-1:0] commonActuatorAlarm
);

  localparam int NK = NUM_STORES * NUM_UNITS;

  // Bus phase tracking
  logic addrOk; // Valid address phase this cycle
  logic rdAcc; // Read taken this cycle
  logic wrPend_r; // Write data phase pending
  logic [7:0] wrOff_r; // Offset of pending write
  logic [31:0] hrdata_r; // Registered read data
  // Software registers
  logic [1:0] storeSel_r; // Selected store
  logic [7:0] unitSel_r; // Selected unit, one-based
  logic [15:0] discAddr_r; // Zero-based discrete address
  // Coil command decode
  logic coilWr; // Coil command write in data phase
  logic [7:0] coilFc; // Function code
  logic [7:0] coilQty; // Coil count for multiple write
  logic [15:0] coilStart; // Zero-based first coil
  logic [NUM_TRIG-1:0] coilHit; // Trigger coils covered
  logic [NUM_STORES-1:0] acceptPulse_r; // Accept per store
  // Read side effects
  logic recRead; // Unit record read
  logic discRead; // Discrete read
  logic recValid; // Unit selection in range
  int selIdx; // Flat store and unit index
  logic [31:0] recValue; // Record value
  logic discValue; // Discrete value
  logic [31:0] rdValue; // Value for read mux
  // Per entry state exported from generate
  logic [ALM_BITS-1:0] almLatchAll [NK];
  logic [NK-1:0] sumAll; // Summary latches
  logic [NK-1:0] newAll; // New-alarm flags
  logic [SYS_ALMS-1:0] sysAll [NUM_STORES];
  logic [NUM_UNITS*ALM_BITS-1:0] srcPrev_r; // For rising edge

  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign addrOk = hsel && hready && htrans[1];
  assign rdAcc = addrOk && !hwrite;
  assign recRead = rdAcc && (haddr[7:0] == OFF_UNIT_REC);
  assign discRead = rdAcc && (haddr[7:0] == OFF_DISC_DATA);

  // Capture write address phase; data follows next cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r <= 1'b0;
      wrOff_r <= 8'h00;
    end else begin
      wrPend_r <= addrOk && hwrite;
      if (addrOk) begin
        wrOff_r <= haddr[7:0];
      end
    end
  end

  // Selection registers steer the read muxes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      storeSel_r <= STORE_SEL_RST;
      unitSel_r <= UNIT_SEL_RST;
      discAddr_r <= DISC_ADDR_RST;
    end else if (wrPend_r) begin
      if (wrOff_r == OFF_STORE_SEL) begin
        // Store 3 does not exist; such writes are dropped
        if (int'(hwdata[1:0]) < NUM_STORES) begin
          storeSel_r <= hwdata[1:0];
        end
      end else if (wrOff_r == OFF_UNIT_SEL) begin
        unitSel_r <= hwdata[7:0];
      end else if (wrOff_r == OFF_DISC_ADDR) begin
        discAddr_r <= hwdata[15:0];
      end
    end
  end

  // Coil command fields; the coil value itself is never looked at
  assign coilWr = wrPend_r && (wrOff_r == OFF_COIL_CMD);
  assign coilFc = hwdata[CMD_FC_LSB +: 8];
  assign coilQty = hwdata[CMD_QTY_LSB +: 8];
  assign coilStart = hwdata[15:0];

  // Which trigger coils a write covers
  always_comb begin
    int first;
    int last;
    first = int'(coilStart);
    last = first;
    coilHit = '0;
    if (coilFc == FC_WRITE_COILS) begin
      // Zero quantity leaves last below first: nothing hit
      last = first + int'(coilQty) - 1;
    end
    for (int i = 0; i < NUM_TRIG; i++) begin
      // Link address is location minus one
      if (coilWr && (coilFc == FC_WRITE_COIL || coilFc == FC_WRITE_COILS) &&
          (COIL_LOC[i] - COIL_LOC_BASE) >= first &&
          (COIL_LOC[i] - COIL_LOC_BASE) <= last) begin
        coilHit[i] = 1'b1;
      end
    end
  end

  // Trigger pulses, one cycle each
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      emergencyShutdownTrigger <= 1'b0;
      changeMasterTrigger <= 1'b0;
      loopResetTrigger <= 1'b0;
      acceptPulse_r <= '0;
    end else begin
      emergencyShutdownTrigger <= coilHit[TRIG_ESD];
      changeMasterTrigger <= coilHit[TRIG_CHANGE];
      loopResetTrigger <= coilHit[TRIG_RESET];
      for (int g = 0; g < NUM_STORES; g++) begin
        // Accept only reaches the store selected for this port
        acceptPulse_r[g] <= coilHit[TRIG_ACCEPT] && (int'(storeSel_r) == g);
      end
    end
  end

  // Previous source levels, shared by all stores
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      srcPrev_r <= '0;
    end else begin
      srcPrev_r <= fieldUnitAlarmSrc;
    end
  end

  // Selected record index
  assign recValid = (unitSel_r != 8'h00) && (int'(unitSel_r) <= NUM_UNITS);
  assign selIdx = int'(storeSel_r) * NUM_UNITS + int'(unitSel_r) - 1;

  // Per store, per unit alarm state
  for (genvar g = 0; g < NUM_STORES; g++) begin : gStore
    for (genvar u = 0; u < NUM_UNITS; u++) begin : gUnit
      localparam int K = g * NUM_UNITS + u;
      logic [ALM_BITS-1:0] latch_r; // Latched alarm block
      logic [ALM_BITS-1:0] rd_r; // Bit read while latched
      logic [ALM_BITS-1:0] acc_r; // Bit accepted after read
      logic sum_r; // Latched summary
      logic sumRd_r; // Summary read
      logic sumAcc_r; // Summary accepted
      logic new_r; // New alarm flag
      logic [ALM_BITS-1:0] src; // Raw sources
      logic [ALM_BITS-1:0] clr; // Bits ready to clear
      logic mark; // Record read of this unit
      logic anySrc; // Raw OR ahead of latches
      logic sumClr; // Summary ready to clear
      assign src = fieldUnitAlarmSrc[u*ALM_BITS +: ALM_BITS];
      assign mark = recRead && recValid && (selIdx == K);
      assign clr = acc_r & ~src;
      assign anySrc = |src;
      assign sumClr = sumAcc_r & ~anySrc;
      assign almLatchAll[K] = latch_r;
      assign sumAll[K] = sum_r;
      assign newAll[K] = new_r;

      // Latch: a live source always holds the bit
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          latch_r <= '0;
        end else begin
          latch_r <= (latch_r & ~clr) | src;
        end
      end

      // Read marks only bits that showed as set
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          rd_r <= '0;
        end else begin
          rd_r <= (rd_r | ({ALM_BITS{mark}} & latch_r)) & ~clr;
        end
      end

      // Accept counts only for bits already read
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_r <= '0;
        end else begin
          acc_r <= (acc_r | ({ALM_BITS{acceptPulse_r[g]}} & rd_r)) & ~clr;
        end
      end

      // Summary flag with its own read and accept
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          sum_r <= 1'b0;
          sumRd_r <= 1'b0;
          sumAcc_r <= 1'b0;
        end else begin
          sum_r <= (sum_r && !sumClr) || anySrc;
          sumRd_r <= (sumRd_r || (mark && sum_r)) && !sumClr;
          sumAcc_r <= (sumAcc_r || (acceptPulse_r[g] && sumRd_r)) && !sumClr;
        end
      end

      // New alarm: rising source edge beats a same-cycle accept
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          new_r <= 1'b0;
        end else if (|(src & ~srcPrev_r[u*ALM_BITS +: ALM_BITS])) begin
          new_r <= 1'b1;
        end else if (acceptPulse_r[g]) begin
          new_r <= 1'b0;
        end
      end
    end

    // System alarms and common actuator alarm of this store
    logic [SYS_ALMS-1:0] sys_r; // Latched system alarms
    logic [SYS_ALMS-1:0] sysRd_r; // Read while latched
    logic [SYS_ALMS-1:0] sysAcc_r; // Accepted after read
    logic [SYS_ALMS-1:0] sysMark; // Discrete read hit
    logic [SYS_ALMS-1:0] sysClr; // Ready to clear
    logic act_r; // Latched monitor relay OR
    logic actRd_r; // Read while latched
    logic actAcc_r; // Accepted after read
    logic actSrc; // Raw monitor relay OR
    logic actMark; // Discrete read hit
    logic actClr; // Ready to clear
    assign actSrc = |monitorRelaySrc;
    assign actClr = actAcc_r && !actSrc;
    assign sysClr = sysAcc_r & ~sysAlarmSrc;
    assign actMark = discRead && (int'(storeSel_r) == g) &&
                     (int'(discAddr_r) == LOC_COMMON_ACT - DISC_LOC_BASE);
    for (genvar s = 0; s < SYS_ALMS; s++) begin : gMark
      assign sysMark[s] = discRead && (int'(storeSel_r) == g) &&
                          (int'(discAddr_r) == LOC_SYS_FIRST + s - DISC_LOC_BASE);
    end
    assign sysAll[g] = sys_r;
    assign commonUnitAlarm[g] = |sumAll[g*NUM_UNITS +: NUM_UNITS];
    assign commonActuatorAlarm[g] = act_r;

    // Same read, accept, normal sequence as the alarm block
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        sys_r <= '0;
        sysRd_r <= '0;
        sysAcc_r <= '0;
      end else begin
        sys_r <= (sys_r & ~sysClr) | sysAlarmSrc;
        sysRd_r <= (sysRd_r | (sysMark & sys_r)) & ~sysClr;
        sysAcc_r <= (sysAcc_r | ({SYS_ALMS{acceptPulse_r[g]}} & sysRd_r)) & ~sysClr;
      end
    end

    // Common actuator alarm latch
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        act_r <= 1'b0;
        actRd_r <= 1'b0;
        actAcc_r <= 1'b0;
      end else begin
        act_r <= (act_r && !actClr) || actSrc;
        actRd_r <= (actRd_r || (actMark && act_r)) && !actClr;
        actAcc_r <= (actAcc_r || (acceptPulse_r[g] && actRd_r)) && !actClr;
      end
    end
  end

  // Unit record assembly; thermostat source lands on bit 19
  always_comb begin
    int u;
    u = int'(unitSel_r) - 1;
    recValue = '0;
    if (recValid) begin
      recValue[REC_ALM_LSB +: ALM_BITS] = almLatchAll[selIdx];
      recValue[REC_SUM_BIT] = sumAll[selIdx];
      recValue[REC_NEW_BIT] = newAll[selIdx];
      recValue[REC_OPEN_BIT] = openLimitStatus[u];
      recValue[REC_CLOSED_BIT] = closedLimitStatus[u];
    end
  end

  // Discrete map, addressed zero-based; unlisted addresses read 0
  always_comb begin
    int da;
    int o;
    int s;
    da = int'(discAddr_r);
    o = 0;
    s = int'(storeSel_r);
    discValue = 1'b0;
    if (da >= LOC_SYS_FIRST - DISC_LOC_BASE &&
        da < LOC_SYS_FIRST + SYS_ALMS - DISC_LOC_BASE) begin
      discValue = sysAll[s][da - (LOC_SYS_FIRST - DISC_LOC_BASE)];
    end else if (da == LOC_LOOP_BUSY - DISC_LOC_BASE) begin
      discValue = loopbackBusy;
    end else if (da == LOC_LOOP_USED - DISC_LOC_BASE) begin
      discValue = loopbackInUse;
    end else if (da == LOC_COMMON_UNIT - DISC_LOC_BASE) begin
      discValue = commonUnitAlarm[s];
    end else if (da == LOC_COMMON_ACT - DISC_LOC_BASE) begin
      discValue = commonActuatorAlarm[s];
    end else if (da == LOC_MAIN_OK - DISC_LOC_BASE) begin
      discValue = mainUnitOk;
    end else if (da == LOC_STANDBY_OK - DISC_LOC_BASE) begin
      discValue = standbyUnitOk;
    end else if (da == LOC_CONTACT - DISC_LOC_BASE) begin
      discValue = contactRight;
    end else if (da == LOC_PRIMARY - DISC_LOC_BASE) begin
      discValue = primaryUnit;
    end else if (da >= LOC_LIMIT_BASE + 1 - DISC_LOC_BASE &&
                 da <= LOC_LIMIT_BASE + 2 * NUM_UNITS - DISC_LOC_BASE) begin
      // Pairs: even offset closed, odd offset open
      o = da - (LOC_LIMIT_BASE + 1 - DISC_LOC_BASE);
      discValue = o[0] ? openLimitStatus[o >> 1] : closedLimitStatus[o >> 1];
    end else if (da >= LOC_OPEN_MIRROR - DISC_LOC_BASE &&
                 da < LOC_OPEN_MIRROR + NUM_UNITS - DISC_LOC_BASE) begin
      discValue = openLimitStatus[da - (LOC_OPEN_MIRROR - DISC_LOC_BASE)];
    end else if (da >= LOC_CLOSED_MIRROR - DISC_LOC_BASE &&
                 da < LOC_CLOSED_MIRROR + NUM_UNITS - DISC_LOC_BASE) begin
      discValue = closedLimitStatus[da - (LOC_CLOSED_MIRROR - DISC_LOC_BASE)];
    end
  end

  // Read mux by offset
  always_comb begin
    rdValue = '0;
    if (haddr[7:0] == OFF_STORE_SEL) begin
      rdValue = 32'(storeSel_r);
    end else if (haddr[7:0] == OFF_UNIT_SEL) begin
      rdValue = 32'(unitSel_r);
    end else if (haddr[7:0] == OFF_UNIT_REC) begin
      rdValue = recValue;
    end else if (haddr[7:0] == OFF_DISC_ADDR) begin
      rdValue = 32'(discAddr_r);
    end else if (haddr[7:0] == OFF_DISC_DATA) begin
      rdValue = 32'(discValue);
    end else if (haddr[7:0] == OFF_STATUS) begin
      rdValue[STAT_UNIT_LSB +: NUM_STORES] = commonUnitAlarm;
      rdValue[STAT_ACT_LSB +: NUM_STORES] = commonActuatorAlarm;
    end
  end

  // Read data sampled at the address phase, shown in the data phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_r <= 32'h00000000;
    end else if (rdAcc) begin
      hrdata_r <= rdValue;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence sEsdWrite;
    coilWr && coilFc == FC_WRITE_COIL && coilStart == 16'h0000;
  endsequence

  sequence sAcceptStore0;
    acceptPulse_r[0] && !acceptPulse_r[1];
  endsequence

  AST_LATCH_SET: assert property (fieldUnitAlarmSrc[0] |=> gStore[0].gUnit[0].latch_r[0])
    else $error("alarm bit did not latch");
  AST_CLEAR_NEEDS_ALL: assert property ($fell(gStore[0].gUnit[0].latch_r[0]) |->
      $past(gStore[0].gUnit[0].rd_r[0]) && $past(gStore[0].gUnit[0].acc_r[0]))
    else $error("alarm cleared without read and accept");
  AST_CLEAR_NORMAL: assert property ($fell(gStore[0].gUnit[0].latch_r[0]) |->
      !$past(fieldUnitAlarmSrc[0]))
    else $error("alarm cleared while source active");
  AST_UNREAD_STAYS: assert property (gStore[0].gUnit[0].latch_r[0] &&
      !gStore[0].gUnit[0].rd_r[0] |=> gStore[0].gUnit[0].latch_r[0])
    else $error("unread alarm bit was lost");
  AST_SUMMARY: assert property ((|fieldUnitAlarmSrc[ALM_BITS-1:0]) |=>
      gStore[0].gUnit[0].sum_r ##0 commonUnitAlarm[0])
    else $error("summary or common alarm missing");
  AST_NEW_CLEAR: assert property (sAcceptStore0 ##0
      !(|(fieldUnitAlarmSrc[ALM_BITS-1:0] & ~srcPrev_r[ALM_BITS-1:0])) |=>
      !gStore[0].gUnit[0].new_r)
    else $error("accept did not clear new alarm");
  AST_STORE_ISOLATED: assert property (sAcceptStore0 ##0 !gStore[1].gUnit[0].new_r |=>
      $stable(gStore[1].gUnit[0].acc_r) || $fell(gStore[1].gUnit[0].latch_r[0]))
    else $error("accept leaked into another store");
  AST_ESD_PULSE: assert property (sEsdWrite |=> emergencyShutdownTrigger ##1
      !emergencyShutdownTrigger || coilWr)
    else $error("trigger coil write gave no single pulse");
  AST_SYS_LATCH: assert property (sysAlarmSrc[0] |=> gStore[0].sys_r[0])
    else $error("system alarm did not latch");

endmodule : alsm_top
